// ==== design/psc_defs.vh ====
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH
// ----------------------------------------------------------------
// Operating modes and pin-state codes
// ----------------------------------------------------------------
`define PSC_MODE_W        3
`define PSC_MODE_SINGLE   3'h7
// Power / bus state selector
`define PSC_ST_W          3
`define PSC_ST_RUN        3'h0
`define PSC_ST_SWSTBY     3'h1
`define PSC_ST_HWSTBY     3'h2
`define PSC_ST_RELEASED   3'h3
// Access phase reported by the bus controller
`define PSC_PH_W          3
`define PSC_PH_IDLE       3'h0
`define PSC_PH_FIRST      3'h1
`define PSC_PH_SECOND     3'h2
`define PSC_PH_WAIT       3'h3
`define PSC_PH_THIRD      3'h4
// Bus widths
`define PSC_ADDR_W        24
`define PSC_DATA_W        16
`define PSC_PORT_W        8
// Half-state delay before address clear, in ns and in clock edges
`define PSC_HALF_STATE_NS 50
`define PSC_CLK_NS        100
`define PSC_ADDR_CLR_CYC  1
// Reset values
`define PSC_ADDR_RST      24'h000000
`define PSC_STROBE_IDLE   4'hF
`endif

// ==== design/psc_hold.v ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Per-pin hold cell: latches drive level and enable on freeze
// ----------------------------------------------------------------
module psc_hold (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  // Control
  input  wire freeze_i,
  // Live pin drive
  input  wire out_i,
  input  wire oe_i,
  // Held pin drive
  output wire out_o,
  output wire oe_o
);
  reg out_q;  // Last driven level
  reg oe_q;   // Last direction

  // ----------------------------------------------------------------
  // Capture while live, hold while frozen
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end else if (ce_i && !freeze_i) begin
      out_q <= out_i;
      oe_q  <= oe_i;
    end
  end

  // Frozen: old output level, inputs stay floating
  assign out_o = freeze_i ? out_q : out_i;
  assign oe_o  = freeze_i ? oe_q  : oe_i;
endmodule // psc_hold
`default_nettype wire

// ==== design/psc_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "psc_defs.vh"
module psc_top (
  // Clock, reset, enable
  input  wire                    clk_i,
  input  wire                    rst_i,
  input  wire                    ce_i,
  // Reset pin and sources
  input  wire                    reset_input_pin_n_i,
  input  wire                    watchdog_timer_ovf_i,
  // Mode and state
  input  wire [`PSC_MODE_W-1:0]  mode_i,
  input  wire [`PSC_ST_W-1:0]    state_i,
  input  wire [`PSC_PH_W-1:0]    phase_i,
  input  wire                    two_state_area_i,
  input  wire                    bus_release_enable_i,
  input  wire                    bus_request_input_n_i,
  // Core-side bus drive
  input  wire [`PSC_ADDR_W-1:0]  addr_i,
  input  wire [`PSC_DATA_W-1:0]  data_i,
  input  wire                    data_oe_i,
  input  wire [3:0]              strobe_n_i,
  // Core-side general ports
  input  wire [`PSC_PORT_W-1:0]  port_out_i,
  input  wire [`PSC_PORT_W-1:0]  port_dir_i,
  // Address pins
  output reg  [`PSC_ADDR_W-1:0]  addr_o,
  output reg                     addr_oe_o,
  // Data pins
  output reg  [`PSC_DATA_W-1:0]  data_o,
  output reg                     data_oe_o,
  // Strobes: address, read, upper write, lower write
  output reg  [3:0]              strobe_n_o,
  output reg                     strobe_oe_o,
  // Bus acknowledge pin
  output reg                     bus_ack_n_o,
  output reg                     bus_ack_oe_o,
  // General port pins
  output wire [`PSC_PORT_W-1:0]  port_o,
  output wire [`PSC_PORT_W-1:0]  port_oe_o,
  // Reset output pin, open drain
  output reg                     reset_output_pin_o,
  output reg                     reset_output_pin_oe_o,
  // Status
  output reg                     bus_released_o,
  output reg                     in_reset_o
);
  // ----------------------------------------------------------------
  // Falling-edge sample of the reset pin
  // ----------------------------------------------------------------
  reg res_fall_q;  // Reset pin as seen at clock fall
  always @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_fall_q <= 1'b0;
    end else if (ce_i) begin
      res_fall_q <= ~reset_input_pin_n_i;
    end
  end

  // Pin low now, or already seen low
  wire res_now = ~reset_input_pin_n_i | res_fall_q;

  // ----------------------------------------------------------------
  // Address handling on reset
  // ----------------------------------------------------------------
  reg [`PSC_PH_W-1:0] hit_ph_q;  // Phase when reset was taken
  reg                 rst_seen_q;
  reg                 addr_clr_q; // Address forced low
  reg [`PSC_ADDR_W-1:0] addr_hold_q;
  // Phase latched on the last edge before the fall sample
  wire early_ph = (hit_ph_q == `PSC_PH_FIRST) ||
                  ((hit_ph_q == `PSC_PH_SECOND) && !two_state_area_i) ||
                  (hit_ph_q == `PSC_PH_WAIT);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hit_ph_q    <= `PSC_PH_IDLE;
      rst_seen_q  <= 1'b0;
      addr_clr_q  <= 1'b0;
      addr_hold_q <= `PSC_ADDR_RST;
    end else if (ce_i) begin
      if (!res_fall_q) begin
        rst_seen_q  <= 1'b0;
        addr_clr_q  <= 1'b0;
        addr_hold_q <= addr_i;
        hit_ph_q    <= phase_i;
      end else if (!rst_seen_q) begin
        // Rising edge after the falling sample: half a state later
        rst_seen_q <= 1'b1;
        addr_clr_q <= early_ph;
      end else begin
        // Held cases clear once their state ends
        addr_clr_q <= 1'b1;
      end
    end
  end

  // Early phases clear on the edge half a state after the sample;
  // waiting for addr_clr_q would cost a whole extra state
  wire addr_clr_now = addr_clr_q || (res_fall_q && !rst_seen_q && early_ph);

  // ----------------------------------------------------------------
  // Bus release, never in single-chip mode
  // ----------------------------------------------------------------
  wire rel_ok = bus_release_enable_i && (mode_i != `PSC_MODE_SINGLE);
  wire released = rel_ok && (state_i == `PSC_ST_RELEASED) && !bus_request_input_n_i;
  wire hw_stby  = (state_i == `PSC_ST_HWSTBY);
  wire sw_stby  = (state_i == `PSC_ST_SWSTBY);
  wire hold_st  = sw_stby || ((state_i == `PSC_ST_RELEASED) && !released);

  // ----------------------------------------------------------------
  // General port pins through hold cells
  // ----------------------------------------------------------------
  wire [`PSC_PORT_W-1:0] held_out;
  wire [`PSC_PORT_W-1:0] held_oe;
  genvar gi;
  generate
    for (gi = 0; gi < `PSC_PORT_W; gi = gi + 1) begin : g_pin
      psc_hold u_hold (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .freeze_i (hold_st),
        .out_i    (port_out_i[gi]),
        .oe_i     (port_dir_i[gi]),
        .out_o    (held_out[gi]),
        .oe_o     (held_oe[gi])
      );
    end
  endgenerate
  // Direction is forced combinationally so the pins turn to inputs
  // the instant the reset pin falls, not on the next edge
  // Reset and hardware standby force inputs
  assign port_o    = held_out;
  assign port_oe_o = (res_now || hw_stby) ? {`PSC_PORT_W{1'b0}} : held_oe;

  // ----------------------------------------------------------------
  // Bus pins: registered drive
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_o       <= `PSC_ADDR_RST;
      addr_oe_o    <= 1'b0;
      data_o       <= {`PSC_DATA_W{1'b0}};
      data_oe_o    <= 1'b0;
      strobe_n_o   <= `PSC_STROBE_IDLE;
      strobe_oe_o  <= 1'b0;
      bus_ack_n_o  <= 1'b1;
      bus_ack_oe_o <= 1'b0;
      bus_released_o <= 1'b0;
      in_reset_o   <= 1'b0;
    end else if (ce_i) begin
      in_reset_o     <= res_now;
      bus_released_o <= released;
      data_o         <= data_i;
      if (hw_stby) begin
        // Everything floats
        addr_oe_o    <= 1'b0;
        data_oe_o    <= 1'b0;
        strobe_oe_o  <= 1'b0;
        bus_ack_oe_o <= 1'b0;
      end else if (res_now) begin
        strobe_n_o  <= `PSC_STROBE_IDLE;
        strobe_oe_o <= 1'b1;
        data_oe_o   <= 1'b0;
        addr_oe_o   <= 1'b1;
        addr_o      <= addr_clr_now ? `PSC_ADDR_RST : addr_hold_q;
        bus_ack_oe_o <= 1'b0;
      end else if (released) begin
        addr_oe_o    <= 1'b0;
        strobe_oe_o  <= 1'b0;
        data_oe_o    <= 1'b0;
        bus_ack_n_o  <= 1'b0;
        bus_ack_oe_o <= 1'b1;
      end else if (sw_stby) begin
        addr_oe_o    <= 1'b0;
        data_oe_o    <= 1'b0;
        strobe_oe_o  <= 1'b0;
        bus_ack_n_o  <= 1'b1;
        bus_ack_oe_o <= rel_ok;
      end else begin
        addr_o       <= addr_i;
        addr_oe_o    <= (mode_i != `PSC_MODE_SINGLE);
        data_oe_o    <= data_oe_i;
        strobe_n_o   <= strobe_n_i;
        strobe_oe_o  <= (mode_i != `PSC_MODE_SINGLE);
        bus_ack_n_o  <= 1'b1;
        bus_ack_oe_o <= rel_ok;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset output: pulled low only for watchdog reset
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_output_pin_o    <= 1'b0;
      reset_output_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      // Open drain: level is always low, only the enable moves
      reset_output_pin_o    <= 1'b0;
      reset_output_pin_oe_o <= watchdog_timer_ovf_i && !hw_stby;
    end
  end
endmodule // psc_top
`default_nettype wire

// ==== dv/pin_state_control_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_state_control_bench;
  // ----
  // Stimulus and pins
  // ----
  logic clk_i = 0, rst_i = 1, ce_i = 1, reset_input_pin_n_i = 1, watchdog_timer_ovf_i = 0, want_bus = 0;
  logic [2:0] mode_i = 0, state_i = 0, phase_i = 0;
  logic two_state_area_i = 0, bus_release_enable_i = 1, data_oe_i = 1;
  logic [23:0] addr_i = 24'hABCDEF;
  logic [15:0] data_i = 16'h1234;
  logic [3:0] strobe_n_i = 4'h0;
  logic [7:0] port_out_i = 8'hA5, port_dir_i = 8'h0F;
  wire bus_request_input_n_i, addr_oe_o, data_oe_o, strobe_oe_o, bus_ack_n_o, bus_ack_oe_o, in_reset_o;
  wire reset_output_pin_o, reset_output_pin_oe_o, bus_released_o;
  wire [23:0] addr_o;
  wire [15:0] data_o;
  wire [3:0] strobe_n_o;
  wire [7:0] port_o, port_oe_o;
  int failures = 0, n_tests = 0;
  always #50 clk_i = ~clk_i;
  psc_top uut (.clk_i, .rst_i, .ce_i, .reset_input_pin_n_i, .watchdog_timer_ovf_i, .mode_i, .state_i, .phase_i,
    .two_state_area_i, .bus_release_enable_i, .bus_request_input_n_i, .addr_i, .data_i, .data_oe_i, .strobe_n_i,
    .port_out_i, .port_dir_i, .addr_o, .addr_oe_o, .data_o, .data_oe_o, .strobe_n_o, .strobe_oe_o, .bus_ack_n_o,
    .bus_ack_oe_o, .port_o, .port_oe_o, .reset_output_pin_o, .reset_output_pin_oe_o, .bus_released_o, .in_reset_o);
  psc_ext_master u_far (.clk_i, .want_bus_i(want_bus), .bus_request_input_n_o(bus_request_input_n_i));
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset pin falls mid-access; hold marks the late-phase case
  task automatic t_pin_reset(input logic [2:0] ph, input logic two, input logic hold);
    phase_i <= ph;
    two_state_area_i <= two;
    cyc(3);
    reset_input_pin_n_i <= 1'b0;
    #1 chk(port_oe_o, 8'h00);
    @(posedge clk_i);
    @(posedge clk_i);
    #1 chk({strobe_oe_o, data_oe_o, strobe_n_o}, 6'h2F);
    chk({in_reset_o, data_o}, {1'b1, 16'h1234});
    chk(addr_o, hold ? 24'hABCDEF : 24'h000000);
    @(posedge clk_i);
    #1 chk(addr_o, hold ? 24'hABCDEF : 24'h000000);
    cyc(1);
    reset_input_pin_n_i <= 1'b1;
    cyc(3);
  endtask
  // Reset output follows only the watchdog overflow
  task automatic t_reset_output_pin;
    watchdog_timer_ovf_i <= 1'b1;
    cyc(2);
    chk({reset_output_pin_oe_o, reset_output_pin_o}, 2'b10);
    watchdog_timer_ovf_i <= 1'b0;
    cyc(2);
    chk(reset_output_pin_oe_o, 1'b0);
    cyc(3);
  endtask
  // Hardware standby floats all; software standby holds port outputs
  task automatic t_standby;
    state_i <= 3'h2;
    cyc(3);
    chk({addr_oe_o, data_oe_o, strobe_oe_o, bus_ack_oe_o, port_oe_o}, 12'h000);
    state_i <= 3'h0;
    cyc(3);
    state_i <= 3'h1;
    cyc(2);
    port_out_i <= 8'h5A;
    cyc(2);
    chk({port_oe_o, port_o[3:0]}, 12'h0F5);
    chk({bus_ack_oe_o, bus_ack_n_o}, 2'b11);
    state_i <= 3'h0;
    cyc(3);
  endtask
  // Far side asks for the bus; refused in single-chip mode
  task automatic t_release(input logic [2:0] m, input logic ok);
    mode_i <= m;
    want_bus <= 1'b1;
    state_i <= 3'h3;
    cyc(4);
    if (ok) chk({bus_released_o, bus_ack_oe_o, bus_ack_n_o, strobe_oe_o, addr_oe_o}, 5'b11000);
    else chk(bus_released_o, 1'b0);
    want_bus <= 1'b0;
    state_i <= 3'h0;
    mode_i <= 3'h0;
    cyc(3);
  endtask
  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    cyc(4);
    rst_i <= 1'b0;
    cyc(2);
    for (int p = 1; p < 4; p++) t_pin_reset(p[2:0], 1'b0, 1'b0);
    t_pin_reset(3'h4, 1'b0, 1'b1);
    t_pin_reset(3'h2, 1'b1, 1'b1);
    t_reset_output_pin;
    t_standby;
    t_release(3'h0, 1'b1);
    t_release(3'h7, 1'b0);
    tally_and_finish;
  end
  initial begin
    #(2000 * 100);
    failures++;
    tally_and_finish;
  end
endmodule // pin_state_control_bench
`default_nettype wire

// ==== dv/psc_ext_master.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// Far-side bus master: asks for the bus
// ----
module psc_ext_master (
  // Clock and command
  input  wire logic clk_i,
  input  wire logic want_bus_i,
  // Request pin, active low
  output var  logic bus_request_input_n_o
);
  // Idle high so no stray request at start
  initial bus_request_input_n_o = 1'b1;
  // Changes only after a clock edge, held until dropped
  always @(posedge clk_i) begin
    bus_request_input_n_o <= !want_bus_i;
  end
endmodule // psc_ext_master
`default_nettype wire

// ==== dv/psc_top_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// Pin state checker
// ----
module psc_checker (
  // Clock, reset, inputs
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        reset_input_pin_n_i,
  input wire logic        watchdog_timer_ovf_i,
  input wire logic [2:0]  mode_i,
  input wire logic [2:0]  state_i,
  input wire logic [2:0]  phase_i,
  input wire logic        two_state_area_i,
  input wire logic [23:0] addr_i,
  // Pins
  input wire logic [23:0] addr_o,
  input wire logic        addr_oe_o,
  input wire logic        data_oe_o,
  input wire logic [3:0]  strobe_n_o,
  input wire logic        strobe_oe_o,
  input wire logic        bus_ack_oe_o,
  input wire logic [7:0]  port_oe_o,
  input wire logic        reset_output_pin_o,
  input wire logic        reset_output_pin_oe_o,
  input wire logic        bus_released_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_PORT_IN: assert property (!reset_input_pin_n_i |-> port_oe_o == 8'h00)
    else $error("port driven while reset pin low");
  AST_STROBE_HI: assert property (!reset_input_pin_n_i && $past(!reset_input_pin_n_i)
    |-> strobe_n_o == 4'hF && strobe_oe_o && !data_oe_o) else $error("strobes or data wrong in reset");
  AST_ADDR_CLR: assert property ((!reset_input_pin_n_i && !two_state_area_i && phase_i inside {1, 2, 3})[*3]
    |-> addr_o == 24'h000000) else $error("address not cleared");
  AST_ADDR_HOLD: assert property (reset_input_pin_n_i ##1 !reset_input_pin_n_i &&
    (phase_i == 3'h4 || (phase_i == 3'h2 && two_state_area_i)) |=> addr_o == $past(addr_i))
    else $error("address not held");
  AST_RESET_OUTPUT_PIN_LOW: assert property (watchdog_timer_ovf_i |=> reset_output_pin_oe_o && !reset_output_pin_o)
    else $error("reset output not low on overflow");
  AST_RESET_OUTPUT_PIN_REL: assert property (!watchdog_timer_ovf_i |=> !reset_output_pin_oe_o)
    else $error("reset output driven without overflow");
  AST_HWSTBY: assert property ((state_i == 3'h2 && reset_input_pin_n_i)[*2]
    |-> {addr_oe_o, data_oe_o, strobe_oe_o, bus_ack_oe_o, port_oe_o} == 12'h000) else $error("pin driven in standby");
  AST_MODE7: assert property ((mode_i == 3'h7)[*2] |-> !bus_released_o)
    else $error("bus released in single chip mode");
  AST_RELEASED: assert property (bus_released_o |-> bus_ack_oe_o && !strobe_oe_o && !addr_oe_o)
    else $error("released pins wrong");
endmodule // psc_checker
bind psc_top psc_checker u_chk (.clk_i, .rst_i, .reset_input_pin_n_i, .watchdog_timer_ovf_i, .mode_i, .state_i,
  .phase_i, .two_state_area_i, .addr_i, .addr_o, .addr_oe_o, .data_oe_o, .strobe_n_o, .strobe_oe_o, .bus_ack_oe_o,
  .port_oe_o, .reset_output_pin_o, .reset_output_pin_oe_o, .bus_released_o);
`default_nettype wire
